// [design/cfg_loader_pkg.sv]
/*
  Constants for the configuration word loader: word addresses in the
  serial configuration memory, field positions of the main configuration
  word, register offsets and bit positions of the register file.
  Assumes a 16-bit word memory reached through a word-read port.
*/
`default_nettype none
package cfg_loader_pkg;
  localparam int WORD_W = 16;
  localparam logic [7:0] EE_ADDR_IA0 = 8'h00;
  localparam logic [7:0] EE_ADDR_IA1 = 8'h01;
  localparam logic [7:0] EE_ADDR_IA2 = 8'h02;
  localparam logic [7:0] EE_ADDR_CFG = 8'h0A;
  localparam logic [7:0] EE_ADDR_PTR = 8'h0D;
  localparam logic [2:0] IDX_CFG = 3'h0;
  localparam logic [2:0] IDX_PTR = 3'h1;
  localparam logic [2:0] IDX_IA0 = 3'h2;
  localparam logic [2:0] IDX_IA1 = 3'h3;
  localparam logic [2:0] IDX_LAST = 3'h4;
  localparam logic [2:0] WORDS_LOADED = 3'h5;
  localparam int SIG_HI = 15;
  localparam int SIG_LO = 14;
  localparam logic [1:0] SIG_VALID = 2'h1;
  localparam int TOP_LO = 13;
  localparam logic [2:0] REV_SUB_KEY = 3'h3;
  localparam int ID_BIT = 13;
  localparam int BOOT_BIT = 11;
  localparam int REV_HI = 10;
  localparam int REV_LO = 8;
  localparam int ALT_BIT = 7;
  localparam int DPD_BIT = 6;
  localparam int WOL_BIT = 5;
  localparam int STB_BIT = 1;
  localparam int MDM_BIT = 0;
  localparam logic [15:0] DEFAULT_WORD = 16'h0000;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0C;
  localparam logic [7:0] REG_PTR = 8'h10;
  localparam logic [7:0] REG_ADDR_LO = 8'h14;
  localparam logic [7:0] REG_ADDR_HI = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1C;
  localparam int CTRL_RELOAD = 0;
  localparam int CTRL_PME_CLR = 1;
  localparam int EV_W = 3;
  localparam int EV_DONE = 0;
  localparam int EV_BADSIG = 1;
  localparam int EV_WAKE = 2;
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DONE  = 2'b10
  } fetch_state_t;
endpackage
`default_nettype wire

// [design/cfg_word_decoder.sv]
/*
  Configuration word loader and decoder with an AHB-Lite register file.
  Assumes a serial memory reader that answers ee_req with a one-cycle
  ee_ack carrying ee_data, and a single AHB-Lite master on hclk.
*/
// Behaviour
// - Fetch five configuration words after reset.
// - Signature 01 in bits 15:14 means valid.
// - Invalid signature applies built-in defaults.
// - Identity-mode bit applied, zero by default.
// - Bit 11 disables expansion ROM window.
// - Revision low bits from word when 011.
// - Bit 7 picks legacy or alternate identity when bit 13 is set.
// - Bit 6 zero allows deep power-down.
// - Bit 5 sets wake-on-packet mode.
// - Wake mode takes words 0-2 as address.
// - Wake packet asserts PME after address load.
// - Bit 1 allows standby, else always active.
// - Bit 0 marks modem on parallel port.
`timescale 1ns/1ps
`default_nettype none
module cfg_word_decoder #(
  parameter logic [7:0] SILICON_REV = 8'hA5 // Value is arbitrary.
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  output logic             ee_req,
  output logic [7:0]       ee_addr,
  input  wire logic        ee_ack,
  input  wire logic [15:0] ee_data,
  input  wire logic        pme_enable,
  input  wire logic        power_state_d3,
  input  wire logic        wake_packet_rx,
  output logic             cfg_done,
  output logic             eeprom_valid,
  output logic             identity_mode,
  output logic             boot_rom_window_disable,
  output logic [7:0]       revision,
  output logic             alternate_identity_select,
  output logic             deep_sleep_allow,
  output logic             wake_on_packet_mode,
  output logic             standby_allow,
  output logic             modem_attached,
  output logic             deep_power_down,
  output logic             pme_n,
  output logic [47:0]      station_address
);
  cfg_loader_pkg::fetch_state_t state, next_state;
  logic [2:0]  idx, next_idx;
  logic        next_ee_req;
  logic [7:0]  next_ee_addr, word_addr;
  logic [15:0] cfg_word, next_cfg_word, ptr_word, next_ptr_word, eff;
  logic        next_cfg_done, next_eeprom_valid, next_identity_mode;
  logic        next_boot_dis, next_alternate_identity_select, next_dsa, next_wol, next_stb;
  logic        next_mdm, next_dpd, next_pme_n, sig_ok;
  logic [7:0]  next_revision;
  logic [47:0] next_station_address;
  logic [cfg_loader_pkg::EV_W-1:0] events;
  logic        reload_req, pme_clr;

  // Loader sequence: main word first, then pointer and address words.
  always_comb
  begin
    next_state = state;
    next_idx = idx;
    next_ee_req = ee_req;
    next_ee_addr = ee_addr;
    next_cfg_word = cfg_word;
    next_ptr_word = ptr_word;
    next_cfg_done = cfg_done;
    next_eeprom_valid = eeprom_valid;
    next_identity_mode = identity_mode;
    next_boot_dis = boot_rom_window_disable;
    next_revision = revision;
    next_alternate_identity_select = alternate_identity_select;
    next_dsa = deep_sleep_allow;
    next_wol = wake_on_packet_mode;
    next_stb = standby_allow;
    next_mdm = modem_attached;
    next_dpd = deep_power_down;
    next_pme_n = pme_n;
    next_station_address = station_address;
    events = '0;
    sig_ok = cfg_word[cfg_loader_pkg::SIG_HI:cfg_loader_pkg::SIG_LO]
             == cfg_loader_pkg::SIG_VALID;
    eff = sig_ok ? cfg_word : cfg_loader_pkg::DEFAULT_WORD;
    case (idx)
      cfg_loader_pkg::IDX_CFG: word_addr = cfg_loader_pkg::EE_ADDR_CFG;
      cfg_loader_pkg::IDX_PTR: word_addr = cfg_loader_pkg::EE_ADDR_PTR;
      cfg_loader_pkg::IDX_IA0: word_addr = cfg_loader_pkg::EE_ADDR_IA0;
      cfg_loader_pkg::IDX_IA1: word_addr = cfg_loader_pkg::EE_ADDR_IA1;
      default:                 word_addr = cfg_loader_pkg::EE_ADDR_IA2;
    endcase
    case (state)
      cfg_loader_pkg::ST_FETCH:
      begin
        next_ee_req = 1'b1;
        next_ee_addr = word_addr;
        next_state = cfg_loader_pkg::ST_WAIT;
      end
      cfg_loader_pkg::ST_WAIT:
      begin
        if (ee_ack)
        begin
          next_ee_req = 1'b0;
          case (idx)
            cfg_loader_pkg::IDX_CFG: next_cfg_word = ee_data;
            cfg_loader_pkg::IDX_PTR: next_ptr_word = ee_data;
            cfg_loader_pkg::IDX_IA0:
              if (eff[cfg_loader_pkg::WOL_BIT])
                next_station_address[15:0] = ee_data;
            cfg_loader_pkg::IDX_IA1:
              if (eff[cfg_loader_pkg::WOL_BIT])
                next_station_address[31:16] = ee_data;
            default:
              if (eff[cfg_loader_pkg::WOL_BIT])
                next_station_address[47:32] = ee_data;
          endcase
          if (idx == cfg_loader_pkg::IDX_LAST)
          begin
            // Fields are applied only now, when the whole load is in.
            next_state = cfg_loader_pkg::ST_DONE;
            next_cfg_done = 1'b1;
            next_eeprom_valid = sig_ok;
            next_identity_mode = eff[cfg_loader_pkg::ID_BIT];
            next_boot_dis = eff[cfg_loader_pkg::BOOT_BIT];
            if (eff[cfg_loader_pkg::SIG_HI:cfg_loader_pkg::TOP_LO]
                == cfg_loader_pkg::REV_SUB_KEY)
              next_revision = {SILICON_REV[7:3],
                eff[cfg_loader_pkg::REV_HI:cfg_loader_pkg::REV_LO]};
            else
              next_revision = SILICON_REV;
            next_alternate_identity_select = sig_ok && eff[cfg_loader_pkg::ID_BIT]
                          && !eff[cfg_loader_pkg::ALT_BIT];
            next_dsa = !eff[cfg_loader_pkg::DPD_BIT];
            next_wol = eff[cfg_loader_pkg::WOL_BIT];
            next_stb = eff[cfg_loader_pkg::STB_BIT];
            next_mdm = eff[cfg_loader_pkg::MDM_BIT];
            events[cfg_loader_pkg::EV_DONE] = 1'b1;
            events[cfg_loader_pkg::EV_BADSIG] = !sig_ok;
          end
          else
          begin
            next_idx = 3'(idx + 3'h1);
            next_state = cfg_loader_pkg::ST_FETCH;
          end
        end
      end
      cfg_loader_pkg::ST_DONE:
      begin
        next_dpd = deep_sleep_allow && !pme_enable && power_state_d3;
        if (pme_clr)
          next_pme_n = 1'b1;
        if (wake_on_packet_mode && wake_packet_rx)
        begin
          next_pme_n = 1'b0;
          events[cfg_loader_pkg::EV_WAKE] = 1'b1;
        end
      end
      default: next_state = cfg_loader_pkg::ST_FETCH;
    endcase
    if (reload_req)
    begin
      // A reload returns every decoded field to its reset value.
      next_state = cfg_loader_pkg::ST_FETCH;
      next_idx = '0;
      next_ee_req = 1'b0;
      next_cfg_done = 1'b0;
      next_eeprom_valid = 1'b0;
      next_identity_mode = 1'b0;
      next_boot_dis = 1'b0;
      next_revision = SILICON_REV;
      next_alternate_identity_select = 1'b0;
      next_dsa = 1'b0;
      next_wol = 1'b0;
      next_stb = 1'b0;
      next_mdm = 1'b0;
      next_dpd = 1'b0;
      next_pme_n = 1'b1;
      next_station_address = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= cfg_loader_pkg::ST_FETCH;
      idx <= '0;
      ee_req <= 1'b0;
      ee_addr <= '0;
      cfg_word <= cfg_loader_pkg::DEFAULT_WORD;
      ptr_word <= cfg_loader_pkg::DEFAULT_WORD;
      cfg_done <= 1'b0;
      eeprom_valid <= 1'b0;
      identity_mode <= 1'b0;
      boot_rom_window_disable <= 1'b0;
      revision <= SILICON_REV;
      alternate_identity_select <= 1'b0;
      deep_sleep_allow <= 1'b0;
      wake_on_packet_mode <= 1'b0;
      standby_allow <= 1'b0;
      modem_attached <= 1'b0;
      deep_power_down <= 1'b0;
      pme_n <= 1'b1;
      station_address <= '0;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      ee_req <= next_ee_req;
      ee_addr <= next_ee_addr;
      cfg_word <= next_cfg_word;
      ptr_word <= next_ptr_word;
      cfg_done <= next_cfg_done;
      eeprom_valid <= next_eeprom_valid;
      identity_mode <= next_identity_mode;
      boot_rom_window_disable <= next_boot_dis;
      revision <= next_revision;
      alternate_identity_select <= next_alternate_identity_select;
      deep_sleep_allow <= next_dsa;
      wake_on_packet_mode <= next_wol;
      standby_allow <= next_stb;
      modem_attached <= next_mdm;
      deep_power_down <= next_dpd;
      pme_n <= next_pme_n;
      station_address <= next_station_address;
    end
  end

  // Register file: zero wait states, read data registered in address phase.
  logic        act, next_act, wr, next_wr, wr_en, next_irq;
  logic [7:0]  addr, next_addr;
  logic [31:0] next_hrdata;
  logic [cfg_loader_pkg::EV_W-1:0] status, next_status, mask, next_mask;

  always_comb
  begin
    next_act = hsel && htrans[1] && hready;
    next_addr = haddr[7:0];
    next_wr = hwrite;
    wr_en = act && wr;
    reload_req = wr_en && addr == cfg_loader_pkg::REG_CTRL
                 && hwdata[cfg_loader_pkg::CTRL_RELOAD];
    pme_clr = wr_en && addr == cfg_loader_pkg::REG_CTRL
              && hwdata[cfg_loader_pkg::CTRL_PME_CLR];
    next_mask = mask;
    next_status = status;
    if (wr_en && addr == cfg_loader_pkg::REG_MASK)
      next_mask = hwdata[cfg_loader_pkg::EV_W-1:0];
    if (wr_en && addr == cfg_loader_pkg::REG_STATUS)
      next_status = status & ~hwdata[cfg_loader_pkg::EV_W-1:0];
    next_status = next_status | events;
    next_irq = |(next_status & next_mask);
    next_hrdata = '0;
    if (next_act && !hwrite)
      case (haddr[7:0])
        cfg_loader_pkg::REG_STATUS:  next_hrdata[2:0] = status;
        cfg_loader_pkg::REG_MASK:    next_hrdata[2:0] = mask;
        cfg_loader_pkg::REG_CFG:     next_hrdata[15:0] = cfg_word;
        cfg_loader_pkg::REG_PTR:     next_hrdata[15:0] = ptr_word;
        cfg_loader_pkg::REG_ADDR_LO: next_hrdata = station_address[31:0];
        cfg_loader_pkg::REG_ADDR_HI:
          next_hrdata[15:0] = station_address[47:32];
        cfg_loader_pkg::REG_STATE:
          next_hrdata[3:0] = {deep_power_down, !pme_n, eeprom_valid, cfg_done};
        default: next_hrdata = '0;
      endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act <= 1'b0;
      wr <= 1'b0;
      addr <= '0;
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      act <= next_act;
      wr <= next_wr;
      addr <= next_addr;
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  logic [2:0] acks;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acks <= '0;
    else if (reload_req)
      acks <= '0;
    else if (ee_ack && ee_req)
      acks <= 3'(acks + 3'h1);
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  five_words_a: assert property ($rose(cfg_done) |->
    acks == cfg_loader_pkg::WORDS_LOADED)
    else $error("load completed without five words");
  sig_valid_a: assert property (cfg_done |-> eeprom_valid ==
    (cfg_word[15:14] == 2'h1)) else $error("signature check wrong");
  defaults_a: assert property (cfg_done && !eeprom_valid |->
    !identity_mode && !boot_rom_window_disable && !wake_on_packet_mode
    && !standby_allow && !modem_attached && revision == SILICON_REV)
    else $error("defaults not applied on bad signature");
  ident_a: assert property (cfg_done |-> identity_mode ==
    (eeprom_valid && cfg_word[13])) else $error("identity mode wrong");
  boot_a: assert property (cfg_done |-> boot_rom_window_disable ==
    (eeprom_valid && cfg_word[11])) else $error("boot disable wrong");
  rev_sub_a: assert property (cfg_done |-> revision ==
    ((cfg_word[15:13] == 3'h3) ? {SILICON_REV[7:3], cfg_word[10:8]}
    : SILICON_REV)) else $error("revision substitution wrong");
  alternate_identity_select_a: assert property (cfg_done |-> alternate_identity_select ==
    (eeprom_valid && cfg_word[13] && !cfg_word[7]))
    else $error("identity select wrong");
  deep_down_a: assert property (deep_power_down |-> $past(cfg_done
    && deep_sleep_allow && !pme_enable && power_state_d3))
    else $error("deep power-down without cause");
  wake_mode_a: assert property ($rose(cfg_done) |->
    wake_on_packet_mode == (eeprom_valid && cfg_word[5]))
    else $error("wake mode wrong");
  addr_seq_a: assert property ($rose(ee_req) && idx == 3'h2 |->
    ee_addr == 8'h00) else $error("address word fetch wrong");
  pme_set_a: assert property (state == cfg_loader_pkg::ST_DONE
    && wake_on_packet_mode && wake_packet_rx && !reload_req |=> !pme_n)
    else $error("wake packet did not assert PME");
  standby_a: assert property (cfg_done |-> standby_allow ==
    (eeprom_valid && cfg_word[1]) && modem_attached ==
    (eeprom_valid && cfg_word[0])) else $error("standby or modem wrong");
  hold_def_a: assert property (!cfg_done |-> !wake_on_packet_mode
    && !deep_power_down && pme_n) else $error("field active before load");

  valid_load_c: cover property ($rose(cfg_done) && eeprom_valid);
  bad_load_c: cover property ($rose(cfg_done) && !eeprom_valid);
  wake_c: cover property ($fell(pme_n));
  irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// [bench/eeprom_model.sv]
/*
  Word-read model of the serial configuration memory.
  Assumes the reader holds req and addr until it sees the one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic [7:0]  addr,
  input  wire logic [3:0]  lag,
  output logic             ack,
  output logic [15:0]      data
);
  logic [15:0] mem [0:255];
  logic [3:0]  cnt;

  // Outside an ack the data lines toggle, so a stale word is inverted on every cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack  <= 1'b0;
      cnt  <= 4'h0;
      data <= 16'h5A5A;
    end
    else if (req && !ack && cnt >= lag)
    begin
      ack  <= 1'b1;
      data <= mem[addr];
    end
    else
    begin
      ack  <= 1'b0;
      cnt  <= (req && !ack) ? cnt + 4'h1 : 4'h0;
      data <= ~data;
    end
  end
endmodule
`default_nettype wire

// [bench/eeprom_config_word_decoder_bench.sv]
/*
  Self-checking bench for the configuration word decoder.
  Assumes the memory model above and a single AHB-Lite master here.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_config_word_decoder_bench;
  localparam logic [7:0] REV = 8'hA5; // Value is arbitrary.
  typedef struct packed {
    logic        use_sa;
    logic [15:0] f;
    logic [47:0] sa;
  } note_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        pme_enable = 1'b0;
  logic        power_state_d3 = 1'b0;
  logic        wake_packet_rx = 1'b0;
  logic [3:0]  lag = 4'h0;
  logic        hreadyout, hresp, irq, ee_req, ee_ack, cfg_done, eeprom_valid;
  logic        identity_mode, boot_rom_window_disable, deep_power_down;
  logic        alternate_identity_select, deep_sleep_allow, pme_n;
  logic        wake_on_packet_mode, standby_allow, modem_attached;
  logic [31:0] hrdata;
  logic [7:0]  ee_addr, revision;
  logic [15:0] ee_data, fv, w;
  logic [47:0] station_address;
  logic [31:0] rs, st;
  logic [31:0] rdq[$];
  note_t       ldq[$];
  note_t       n;
  logic        dph = 1'b0;
  logic        prev_done = 1'b0;
  logic        ok, wk;
  int          eidx = 0;
  int          bad_count = 0;
  int          checks = 0;
  logic [7:0]  order [5] = '{8'h0A, 8'h0D, 8'h00, 8'h01, 8'h02};

  cfg_word_decoder #(.SILICON_REV(REV)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .ee_req(ee_req), .ee_addr(ee_addr),
    .ee_ack(ee_ack), .ee_data(ee_data), .pme_enable(pme_enable),
    .power_state_d3(power_state_d3), .wake_packet_rx(wake_packet_rx),
    .cfg_done(cfg_done), .eeprom_valid(eeprom_valid),
    .identity_mode(identity_mode),
    .boot_rom_window_disable(boot_rom_window_disable),
    .revision(revision),
    .alternate_identity_select(alternate_identity_select),
    .deep_sleep_allow(deep_sleep_allow),
    .wake_on_packet_mode(wake_on_packet_mode),
    .standby_allow(standby_allow), .modem_attached(modem_attached),
    .deep_power_down(deep_power_down), .pme_n(pme_n),
    .station_address(station_address)
  );
  eeprom_model i_mem (
    .clk(hclk), .rst_n(hresetn), .req(ee_req), .addr(ee_addr), .lag(lag),
    .ack(ee_ack), .data(ee_data)
  );

  assign fv = {eeprom_valid, identity_mode, boot_rom_window_disable,
               revision, alternate_identity_select, deep_sleep_allow,
               wake_on_packet_mode, standby_allow, modem_attached};

  always #50 hclk = ~hclk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic note_t expect_load(input logic [15:0] v,
                                        input logic [47:0] sa);
    note_t e;
    logic  good;
    good = (v[15:14] == 2'b01);
    e.use_sa = good && v[5];
    e.sa = sa;
    if (good)
      e.f = {1'b1, v[13], v[11], (v[15:13] == 3'b011) ? {REV[7:3], v[10:8]}
             : REV, v[13] & ~v[7], ~v[6], v[5], v[1],
             v[0]};
    else
      e.f = {3'b000, REV, 5'b01000};
    return e;
  endfunction

  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic prep(input logic [15:0] v);
    rs = xs(rs);
    i_mem.mem[0] = rs[15:0];
    i_mem.mem[1] = rs[31:16];
    rs = xs(rs);
    i_mem.mem[2] = rs[15:0];
    i_mem.mem[8'h0D] = rs[31:16];
    i_mem.mem[8'h0A] = v;
    ldq.push_back(expect_load(v, {i_mem.mem[2], i_mem.mem[1], i_mem.mem[0]}));
  endtask

  task automatic wait_done;
    while (cfg_done !== 1'b1)
      @(posedge hclk);
  endtask

  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Results are compared in the cycle in which they appear.
  always @(posedge hclk)
  begin
    if (dph && hreadyout === 1'b1)
    begin
      check("hrdata", 64'(hrdata), 64'(rdq.pop_front()));
      check("hresp", 64'(hresp), 64'h0);
    end
    dph = hsel && htrans[1] && hreadyout && !hwrite;
    if (ee_req === 1'b1 && ee_ack === 1'b1)
    begin
      check("ee_addr", 64'(ee_addr), 64'(order[eidx]));
      eidx = (eidx + 1) % 5;
    end
    if (cfg_done === 1'b1 && !prev_done && ldq.size() > 0)
    begin
      n = ldq.pop_front();
      check("fields", 64'(fv), 64'(n.f));
      check("station_address", 64'(station_address),
            n.use_sa ? 64'(n.sa) : 64'h0);
    end
    prev_done = (cfg_done === 1'b1);
  end

  initial
  begin
    #2000000;
    bad_count++;
    complete_run();
  end

  initial
  begin
    rs = 32'h9B70;
    prep(16'h6BE3);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wait_done();
    bus(1'b1, cfg_loader_pkg::REG_CFG, 32'hFFFFFFFF);
    rd(cfg_loader_pkg::REG_CFG, 32'h6BE3);
    rd(cfg_loader_pkg::REG_STATUS, 32'h1);
    rd(cfg_loader_pkg::REG_STATE, 32'h3);
    rd(cfg_loader_pkg::REG_ADDR_HI, {16'h0, i_mem.mem[2]});
    rd(cfg_loader_pkg::REG_ADDR_LO, {i_mem.mem[1], i_mem.mem[0]});
    rd(cfg_loader_pkg::REG_PTR, {16'h0, i_mem.mem[8'h0D]});
    rd(8'h40, 32'h0);
    for (int it = 0; it < 9; it++)
    begin
      rs = xs(rs);
      w = rs[15:0];
      w[15:14] = (it % 3 == 0) ? {rs[16], rs[16]} : 2'b01;
      w[12] = 1'b0;
      @(posedge hclk);
      lag <= rs[21:18];
      pme_enable <= rs[22];
      power_state_d3 <= rs[23];
      bus(1'b1, cfg_loader_pkg::REG_STATUS, 32'h7);
      bus(1'b1, cfg_loader_pkg::REG_MASK, {29'h0, rs[26:24]});
      st = {29'h0, rs[26:24]};
      rd(cfg_loader_pkg::REG_MASK, st);
      prep(w);
      bus(1'b1, cfg_loader_pkg::REG_CTRL, 32'h1);
      @(negedge hclk);
      check("cfg_done", 64'(cfg_done), 64'h0);
      check("deep_sleep_allow", 64'(deep_sleep_allow), 64'h0);
      wait_done();
      ok = (w[15:14] == 2'b01);
      wk = ok && w[5];
      rd(cfg_loader_pkg::REG_STATUS, {30'h0, ~ok, 1'b1});
      @(posedge hclk);
      wake_packet_rx <= 1'b1;
      @(posedge hclk);
      wake_packet_rx <= 1'b0;
      @(negedge hclk);
      check("pme_n", 64'(pme_n), 64'(!wk));
      check("deep_power_down", 64'(deep_power_down),
            64'((!ok || !w[6]) && !pme_enable && power_state_d3));
      @(negedge hclk);
      check("irq", 64'(irq), 64'(|(st[2:0] & {wk, ~ok, 1'b1})));
      bus(1'b1, cfg_loader_pkg::REG_CTRL, 32'h2);
      @(negedge hclk);
      check("pme_n", 64'(pme_n), 64'h1);
    end
    complete_run();
  end
endmodule
`default_nettype wire
